// ### src/acs_pkg.sv
// Constants, types and helpers shared by the converter channel sequencer
package acs_pkg;

    // ------------------------------------------------------------------
    // Clocking and timing
    // ------------------------------------------------------------------
    localparam int ACS_CLK_MHZ     = 50;
    localparam int ACS_CLK_HZ      = ACS_CLK_MHZ * 1_000_000;
    localparam int ACS_OSC_HZ      = 1_228_800;
    localparam int ACS_OSC_DIV     = 16;
    localparam int ACS_ADC_CLK_HZ  = ACS_OSC_HZ / ACS_OSC_DIV;
    // One converter clock period in system cycles, rounded up
    localparam int ACS_TICK_CYCLES =
        (ACS_CLK_HZ * ACS_OSC_DIV + ACS_OSC_HZ - 1) / ACS_OSC_HZ;
    localparam int ACS_WAKE_US     = 210;
    localparam int ACS_WAKE_CYCLES = ACS_WAKE_US * ACS_CLK_MHZ;
    localparam int ACS_MIN_TICKS   = 20;
    localparam int ACS_RATE_640_HZ  = 640;
    localparam int ACS_RATE_1280_HZ = 1280;
    localparam int ACS_RATE_2560_HZ = 2560;
    localparam int ACS_RATE_3840_HZ = 3840;
    localparam int ACS_TICKS_640   = ACS_ADC_CLK_HZ / ACS_RATE_640_HZ;
    localparam int ACS_TICKS_1280  = ACS_ADC_CLK_HZ / ACS_RATE_1280_HZ;
    localparam int ACS_TICKS_2560  = ACS_ADC_CLK_HZ / ACS_RATE_2560_HZ;
    localparam int ACS_TICKS_3840  = ACS_ADC_CLK_HZ / ACS_RATE_3840_HZ;
    localparam int ACS_DIV_W       = 10;
    localparam int ACS_WAKE_W      = 14;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] ACS_IDX_CONFIG  = 6'h20;
    localparam logic [5:0] ACS_IDX_INDEX   = 6'h21;
    localparam logic [5:0] ACS_IDX_TRIGGER = 6'h22;
    localparam logic [5:0] ACS_IDX_STATUS  = 6'h23;
    localparam logic [5:0] ACS_IDX_AIN_A   = 6'h24;
    localparam logic [5:0] ACS_IDX_AIN_B   = 6'h25;
    localparam logic [5:0] ACS_IDX_TEMP    = 6'h26;
    localparam logic [5:0] ACS_IDX_OFFSET  = 6'h28;
    localparam logic [5:0] ACS_IDX_BYPASS  = 6'h2e;

    // Field positions
    localparam int ACS_CFG_SINGLE  = 0;
    localparam int ACS_CFG_RANGE   = 1;
    localparam int ACS_CFG_RATE_LO = 2;
    localparam int ACS_CFG_INPUT_BUFFER_POWERDOWN  = 4;
    localparam int ACS_CFG_B_EN    = 5;
    localparam int ACS_IDX_FIRST_LO = 0;
    localparam int ACS_IDX_LAST_LO  = 4;
    localparam int ACS_TRIG_BIT    = 0;
    localparam int ACS_ST_BUSY     = 0;
    localparam int ACS_ST_WAKE     = 1;
    localparam int ACS_ST_SLOT_LO  = 4;
    localparam int ACS_BYP_SKIP    = 0;

    // ------------------------------------------------------------------
    // Slots and values
    // ------------------------------------------------------------------
    localparam logic [3:0]  ACS_SLOT_OFFSET = 4'h0;
    localparam logic [3:0]  ACS_SLOT_A      = 4'h1;
    localparam logic [3:0]  ACS_SLOT_B      = 4'h2;
    localparam logic [3:0]  ACS_SLOT_TEMP   = 4'h3;
    localparam logic [3:0]  ACS_SLOT_DOUBLE = 4'h8;
    localparam logic [3:0]  ACS_FIRST_RESET = 4'h0;
    localparam logic [3:0]  ACS_LAST_RESET  = 4'h8;
    localparam logic [1:0]  ACS_RATE_RESET  = 2'h2;
    localparam logic [11:0] ACS_OFFSET_MID  = 12'h7ff;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ACS_IDLE, ACS_WAIT, ACS_CONV} acs_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } acs_avs_req_s;

    typedef struct packed {
        logic [3:0] channel_slot_pointer;
        logic       range_double;
        logic       converting;
    } acs_mux_s;

    typedef struct packed {
        acs_state_e            st;
        logic [3:0]            slot;
        logic [6:0]            tick_cnt;
        logic [ACS_DIV_W-1:0]  div_cnt;
        logic [ACS_WAKE_W-1:0] wake_cnt;
        logic                  wake_done;
        logic                  single_mode;
        logic                  external_range_bit;
        logic [1:0]            sample_rate_field;
        logic                  input_buffer_powerdown;
        logic                  ext_b_enable;
        logic                  offset_correction_skip;
        logic [3:0]            first;
        logic [3:0]            last;
        logic                  trigger;
        logic [11:0]           res_a;
        logic [11:0]           res_b;
        logic [11:0]           res_temp;
        logic [15:0]           offset;
        logic                  ack;
        logic [31:0]           rdata;
    } acs_state_s;

    localparam acs_state_s ACS_STATE_RESET = '{
        st:                     ACS_IDLE,
        first:                  ACS_FIRST_RESET,
        last:                   ACS_LAST_RESET,
        sample_rate_field:      ACS_RATE_RESET,
        input_buffer_powerdown: 1'b1,
        default:                '0
    };

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [6:0] acs_ticks(input logic [3:0] slot,
                                             input logic [1:0] rate);
        logic [6:0] t;
        t = 7'(ACS_TICKS_2560);
        if (slot == ACS_SLOT_A || slot == ACS_SLOT_B)
        begin
            case (rate)
                2'h0:    t = 7'(ACS_TICKS_640);
                2'h1:    t = 7'(ACS_TICKS_1280);
                2'h2:    t = 7'(ACS_TICKS_2560);
                default: t = 7'(ACS_TICKS_3840);
            endcase
        end
        if (t < 7'(ACS_MIN_TICKS))
            t = 7'(ACS_MIN_TICKS);
        return t;
    endfunction

    function automatic logic acs_range_double(input logic [3:0] slot,
                                              input logic       ext_rng);
        if (slot == ACS_SLOT_DOUBLE)
            return 1'b1;
        if (slot == ACS_SLOT_A || slot == ACS_SLOT_B)
            return ~ext_rng;
        return 1'b0;
    endfunction

    function automatic logic [11:0] acs_correct(input logic [11:0] raw,
                                                input logic [11:0] ofs,
                                                input logic        skip);
        logic signed [13:0] v;
        v = $signed({2'h0, raw}) - $signed({{2{ofs[11]}}, ofs});
        if (skip)
            return raw;
        if (v < 14'sh0000)
            return 12'h000;
        if (v > 14'sh0fff)
            return 12'hfff;
        return v[11:0];
    endfunction

endpackage

// ### src/acs_top.sv
// Converter channel sequencer with Avalon-MM register slave
`timescale 1ns/1ps

module acs_top
    import acs_pkg::*;
#(
    parameter int TICK_CYCLES = ACS_TICK_CYCLES,
    parameter int WAKE_CYCLES = ACS_WAKE_CYCLES
)
(
    input  logic         clk,
    input  logic         reset_n,
    input  acs_avs_req_s avs_req,
    output logic [31:0]  avs_readdata,
    output logic         avs_waitrequest,
    input  logic [11:0]  conv_data,
    output acs_mux_s     mux_ctrl
);

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    acs_state_s s_q;
    acs_state_s s_d;

    logic        req;
    logic        aligned;
    logic [5:0]  sel;
    logic        take;
    logic        wr;
    logic        tick;
    logic [3:0]  eff_last;
    logic [6:0]  need;
    logic        done;
    logic        at_end;
    logic        wr_trig;
    logic [11:0] ofs_diff;

    assign req      = avs_req.read | avs_req.write;
    assign aligned  = avs_req.address[1:0] == 2'h0;
    assign sel      = avs_req.address[7:2];
    // A request completes at the edge where the ack flop is already set
    assign take     = req & s_q.ack;
    assign wr       = take & avs_req.write & aligned & avs_req.byteenable[0];
    assign wr_trig  = wr & (sel == ACS_IDX_TRIGGER);
    assign tick     = s_q.div_cnt == ACS_DIV_W'(TICK_CYCLES - 1);
    assign eff_last = (s_q.first > s_q.last) ? s_q.first : s_q.last;
    assign need     = acs_ticks(s_q.slot,
                                s_q.sample_rate_field);
    assign done     = (s_q.st == ACS_CONV) && tick
                      && (s_q.tick_cnt == need - 7'h01);
    assign at_end   = s_q.slot == eff_last;
    assign ofs_diff = ACS_OFFSET_MID - conv_data;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;

        // Buffer wake-up timer; an early trigger just waits for it
        if (s_q.input_buffer_powerdown)
        begin
            s_d.wake_cnt  = '0;
            s_d.wake_done = 1'b0;
        end
        else if (!s_q.wake_done)
        begin
            if (s_q.wake_cnt == ACS_WAKE_W'(WAKE_CYCLES - 1))
                s_d.wake_done = 1'b1;
            else
                s_d.wake_cnt = s_q.wake_cnt + 1'b1;
        end

        // Converter clock divider only runs while converting
        if (s_q.st == ACS_CONV && !tick)
            s_d.div_cnt = s_q.div_cnt + 1'b1;
        else
            s_d.div_cnt = '0;

        case (s_q.st)
            ACS_IDLE:
            begin
                s_d.tick_cnt = '0;
                if (s_q.trigger)
                    s_d.st = ACS_WAIT;
            end
            ACS_WAIT:
            begin
                if (!s_q.trigger)
                    s_d.st = ACS_IDLE;
                else if (s_q.wake_done)
                begin
                    s_d.st   = ACS_CONV;
                    s_d.slot = s_q.first;
                end
            end
            ACS_CONV:
            begin
                if (tick)
                    s_d.tick_cnt = s_q.tick_cnt + 7'h01;
                if (done)
                begin
                    s_d.tick_cnt = '0;
                    case (s_q.slot)
                        ACS_SLOT_OFFSET:
                            s_d.offset = {{4{ofs_diff[11]}},
                                          ofs_diff};
                        ACS_SLOT_A:
                            s_d.res_a = acs_correct(conv_data,
                                s_q.offset[11:0],
                                s_q.offset_correction_skip);
                        ACS_SLOT_B:
                            s_d.res_b = s_q.ext_b_enable
                                ? acs_correct(conv_data, s_q.offset[11:0],
                                              s_q.offset_correction_skip)
                                : 12'h000;
                        ACS_SLOT_TEMP:
                            s_d.res_temp = acs_correct(conv_data,
                                s_q.offset[11:0],
                                s_q.offset_correction_skip);
                        default:
                            s_d.res_temp = s_q.res_temp;
                    endcase
                    if (!s_q.trigger)
                        s_d.st = ACS_IDLE;
                    else if (at_end)
                    begin
                        if (s_q.single_mode)
                        begin
                            s_d.trigger = 1'b0;
                            s_d.st      = ACS_IDLE;
                        end
                        else
                            s_d.slot = s_q.first;
                    end
                    else
                        s_d.slot = s_q.slot + 4'h1;
                end
            end
            default:
                s_d.st = ACS_IDLE;
        endcase

        // Bus writes come last so a software set beats a hardware clear
        if (wr)
        begin
            if (sel == ACS_IDX_CONFIG)
            begin
                s_d.single_mode = avs_req.writedata[ACS_CFG_SINGLE];
                s_d.external_range_bit =
                    avs_req.writedata[ACS_CFG_RANGE];
                s_d.sample_rate_field =
                    avs_req.writedata[ACS_CFG_RATE_LO +: 2];
                s_d.input_buffer_powerdown =
                    avs_req.writedata[ACS_CFG_INPUT_BUFFER_POWERDOWN];
                s_d.ext_b_enable = avs_req.writedata[ACS_CFG_B_EN];
            end
            else if (sel == ACS_IDX_INDEX)
            begin
                s_d.first = avs_req.writedata[ACS_IDX_FIRST_LO +: 4];
                s_d.last  = avs_req.writedata[ACS_IDX_LAST_LO +: 4];
            end
            else if (sel == ACS_IDX_TRIGGER)
                s_d.trigger = avs_req.writedata[ACS_TRIG_BIT];
            else if (sel == ACS_IDX_BYPASS)
                s_d.offset_correction_skip =
                    avs_req.writedata[ACS_BYP_SKIP];
        end

        // Read data is prepared in the wait cycle; reads have no side effect
        s_d.ack = req & ~s_q.ack;
        if (req && !s_q.ack)
        begin
            s_d.rdata = 32'h0000_0000;
            if (!avs_req.read || !aligned)
                s_d.rdata = 32'h0000_0000;
            else if (sel == ACS_IDX_CONFIG)
            begin
                s_d.rdata[ACS_CFG_SINGLE]      = s_q.single_mode;
                s_d.rdata[ACS_CFG_RANGE]       = s_q.external_range_bit;
                s_d.rdata[ACS_CFG_RATE_LO +: 2] = s_q.sample_rate_field;
                s_d.rdata[ACS_CFG_INPUT_BUFFER_POWERDOWN]      = s_q.input_buffer_powerdown;
                s_d.rdata[ACS_CFG_B_EN]        = s_q.ext_b_enable;
            end
            else if (sel == ACS_IDX_INDEX)
            begin
                s_d.rdata[ACS_IDX_FIRST_LO +: 4] = s_q.first;
                s_d.rdata[ACS_IDX_LAST_LO +: 4]  = s_q.last;
            end
            else if (sel == ACS_IDX_TRIGGER)
                s_d.rdata[ACS_TRIG_BIT] = s_q.trigger;
            else if (sel == ACS_IDX_STATUS)
            begin
                s_d.rdata[ACS_ST_BUSY] = s_q.st != ACS_IDLE;
                s_d.rdata[ACS_ST_WAKE] = s_q.wake_done;
                s_d.rdata[ACS_ST_SLOT_LO +: 4] = s_q.slot;
            end
            else if (sel == ACS_IDX_AIN_A)
                s_d.rdata[11:0] = s_q.res_a;
            else if (sel == ACS_IDX_AIN_B)
                s_d.rdata[11:0] = s_q.res_b;
            else if (sel == ACS_IDX_TEMP)
                s_d.rdata[11:0] = s_q.res_temp;
            else if (sel == ACS_IDX_OFFSET)
                s_d.rdata[15:0] = s_q.offset;
            else if (sel == ACS_IDX_BYPASS)
                s_d.rdata[ACS_BYP_SKIP] = s_q.offset_correction_skip;
            else
                s_d.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            s_q <= ACS_STATE_RESET;
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = req & ~s_q.ack;

    always_comb
    begin
        mux_ctrl.channel_slot_pointer = s_q.slot;
        mux_ctrl.range_double =
            acs_range_double(s_q.slot, s_q.external_range_bit);
        mux_ctrl.converting = s_q.st == ACS_CONV;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking acs_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_IDLE_HOLDS: assert property (
        (s_q.st == ACS_IDLE && !s_q.trigger && !wr_trig)
        |=> (s_q.st == ACS_IDLE) [*2])
        else $error("left idle without a trigger");

    AST_BUSY_ON_START: assert property (
        (s_q.st == ACS_IDLE && s_q.trigger) |=> s_q.st != ACS_IDLE)
        else $error("busy did not rise on trigger");

    AST_START_FIRST: assert property (
        (s_q.st == ACS_WAIT && s_q.trigger && s_q.wake_done)
        |=> (s_q.st == ACS_CONV && s_q.slot == $past(s_q.first)))
        else $error("sequence did not start at first slot");

    AST_SPAN: assert property (
        (s_q.st == ACS_CONV && !$changed(s_q.first) && !$changed(s_q.last))
        |-> (s_q.slot >= s_q.first && s_q.slot <= eff_last))
        else $error("slot outside selected span");

    AST_MIN_CONV: assert property (
        done |-> s_q.tick_cnt >= 7'(ACS_MIN_TICKS - 1))
        else $error("conversion shorter than twenty ticks");

    AST_ADVANCE: assert property (
        (done && s_q.trigger && !at_end)
        |=> s_q.slot == $past(s_q.slot) + 4'h1)
        else $error("slot did not advance by one");

    AST_WRAP: assert property (
        (done && s_q.trigger && at_end && !s_q.single_mode && !wr)
        |=> (s_q.slot == s_q.first && s_q.st == ACS_CONV))
        else $error("repeating mode did not wrap");

    AST_SINGLE_END: assert property (
        (done && s_q.trigger && at_end && s_q.single_mode && !wr_trig)
        |=> (!s_q.trigger && s_q.st == ACS_IDLE))
        else $error("single pass did not self-clear");

    AST_B_ZERO: assert property (
        (done && s_q.slot == ACS_SLOT_B && !s_q.ext_b_enable)
        |=> s_q.res_b == 12'h000)
        else $error("disabled input B not zero");

    AST_OFFSET: assert property (
        (done && s_q.slot == ACS_SLOT_OFFSET)
        |=> s_q.offset[11:0] == ACS_OFFSET_MID - $past(conv_data))
        else $error("offset value wrong");

    AST_STOP: assert property (
        (done && !s_q.trigger && !wr_trig) |=> s_q.st == ACS_IDLE)
        else $error("converter did not stop after current slot");

    AST_RESET_IDX: assert property (
        $rose(reset_n) |-> (s_q.first == ACS_FIRST_RESET
                            && s_q.last == ACS_LAST_RESET))
        else $error("index reset values wrong");

    // ------------------------------------------------------------------
    // Wake, range, hold and bus checks
    // ------------------------------------------------------------------
    // The wake gate is the device half of the buffer settling rule
    AST_WAKE_GATE: assert property (
        (s_q.st == ACS_WAIT && !s_q.wake_done) |=> s_q.st != ACS_CONV)
        else $error("conversion started before buffer wake-up");

    AST_SLOT_HOLD: assert property (
        (s_q.st == ACS_CONV && !done)
        |=> (s_q.st == ACS_CONV && $stable(s_q.slot)))
        else $error("slot left before its conversion finished");

    AST_DOUBLE_SLOT: assert property (
        (s_q.slot == ACS_SLOT_DOUBLE) |-> mux_ctrl.range_double)
        else $error("output node slot not at double range");

    AST_FIXED_RANGE: assert property (
        (s_q.slot != ACS_SLOT_A && s_q.slot != ACS_SLOT_B
         && s_q.slot != ACS_SLOT_DOUBLE) |-> !mux_ctrl.range_double)
        else $error("fixed slot not at reference range");

    AST_EXT_RANGE: assert property (
        (s_q.slot == ACS_SLOT_A || s_q.slot == ACS_SLOT_B)
        |-> (mux_ctrl.range_double == !s_q.external_range_bit))
        else $error("external range bit not applied");

    // Reads must never stall behind a conversion in progress
    AST_ONE_WAIT: assert property (
        (req && avs_waitrequest) |=> (!avs_waitrequest || !req))
        else $error("register access took more than one wait cycle");

    AST_RESULT_HOLD: assert property (
        !(done && s_q.slot == ACS_SLOT_A) |=> $stable(s_q.res_a))
        else $error("input A result changed without a conversion");

    COV_SINGLE: cover property (
        done && at_end && s_q.single_mode ##1 s_q.st == ACS_IDLE);
    COV_WRAP: cover property (
        done && at_end && !s_q.single_mode && s_q.trigger);
    COV_OFFSET: cover property (done && s_q.slot == ACS_SLOT_OFFSET);
    COV_READ_A: cover property (
        take && avs_req.read && sel == ACS_IDX_AIN_A);
    // Repeating run stopped by software at the end of a slot
    COV_STOP: cover property (done && !s_q.trigger);

endmodule

// ### tb/acs_top_test.sv
// Self-checking bench for the converter channel sequencer
`timescale 1ns/1ps
module acs_top_test
    import acs_pkg::*;
;
    logic         clk;
    logic         reset_n;
    acs_avs_req_s avs_req;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic [11:0]  conv_data;
    acs_mux_s     mux_ctrl;
    int           num_errors;
    int           check_count;
    logic [31:0]  rd;
    logic [3:0]   run_slot[$];
    logic         run_rng[$];
    int           run_len[$];
    logic         prev_conv;
    logic [3:0]   prev_slot;
    int           hz[4] = '{640, 1280, 2560, 3840};

    // Short tick and wake counts keep the run brief
    acs_top #(.TICK_CYCLES(2), .WAKE_CYCLES(4)) u_acs_top
    (
        .clk             (clk),
        .reset_n         (reset_n),
        .avs_req         (avs_req),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .conv_data       (conv_data),
        .mux_ctrl        (mux_ctrl)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Each run of one slot while converting: slot, range, length
    always @(posedge clk)
    begin
        if (mux_ctrl.converting === 1'b1)
        begin
            if (prev_conv !== 1'b1
                || mux_ctrl.channel_slot_pointer !== prev_slot)
            begin
                run_slot.push_back(mux_ctrl.channel_slot_pointer);
                run_rng.push_back(mux_ctrl.range_double);
                run_len.push_back(1);
            end
            else
                run_len[run_len.size()-1]++;
        end
        prev_conv <= mux_ctrl.converting;
        prev_slot <= mux_ctrl.channel_slot_pointer;
    end

    // ------------------------------------------------------------
    // Bus access and checking
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] idx,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_req <= '{read: ~wr, write: wr, address: {idx, 2'h0},
                     writedata: wd, byteenable: 4'hf};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            check("waitrequest", 32'h1, 32'h0);
        rd = avs_readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask

    task automatic run(input logic [7:0] cfg, input logic [7:0] ix);
        int n;
        n = 0;
        bus(1'b1, ACS_IDX_CONFIG, {24'h0, cfg});
        bus(1'b1, ACS_IDX_INDEX, {24'h0, ix});
        run_slot.delete();
        run_rng.delete();
        run_len.delete();
        bus(1'b1, ACS_IDX_TRIGGER, 32'h1);
        bus(1'b0, ACS_IDX_STATUS, 32'h0);
        check("busy", {31'h0, rd[ACS_ST_BUSY]}, 32'h1);
        check("wake", {31'h0, rd[ACS_ST_WAKE]}, 32'h1);
        if (cfg[ACS_CFG_SINGLE] == 1'b0)
        begin
            while (run_slot.size() < 3 && n < 3000)
            begin
                @(posedge clk);
                n++;
            end
            bus(1'b1, ACS_IDX_TRIGGER, 32'h0);
        end
        // Polling reads run alongside the conversions on purpose
        do
            bus(1'b0, ACS_IDX_STATUS, 32'h0);
        while (rd[ACS_ST_BUSY] !== 1'b0 && n++ < 3000);
        check("busy end", {31'h0, rd[ACS_ST_BUSY]}, 32'h0);
        bus(1'b0, ACS_IDX_TRIGGER, 32'h0);
        check("trigger", rd, 32'h0);
    endtask

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        reset_n = 1'b0;
        avs_req = '0;
        conv_data = 12'h123;
        num_errors = 0;
        check_count = 0;
        prev_conv = 1'b0;
        prev_slot = 4'h0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, ACS_IDX_CONFIG, 32'h0);
        check("config reset", rd, 32'h18);
        bus(1'b0, ACS_IDX_INDEX, 32'h0);
        check("index reset", rd, 32'h80);
        bus(1'b0, ACS_IDX_STATUS, 32'h0);
        check("idle busy", rd & 32'h1, 32'h0);
        bus(1'b0, 6'h3c, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, ACS_IDX_BYPASS, 32'h1);
        run(8'h09, 8'h30);
        check("slot count", run_slot.size(), 32'h4);
        for (int i = 0; i < 4; i++)
            check("slot order", {28'h0, run_slot[i]}, i);
        check("offset slot len", run_len[0], 32'd60);
        check("range a", {31'h0, run_rng[1]}, 32'h1);
        bus(1'b0, ACS_IDX_AIN_A, 32'h0);
        check("result a", rd, 32'h123);
        bus(1'b0, ACS_IDX_AIN_B, 32'h0);
        check("result b off", rd, 32'h0);
        bus(1'b0, ACS_IDX_TEMP, 32'h0);
        check("result temp", rd, 32'h123);
        bus(1'b0, ACS_IDX_OFFSET, 32'h0);
        check("offset", rd, 32'h6dc);
        bus(1'b1, ACS_IDX_BYPASS, 32'h0);
        conv_data <= 12'h7f0;
        run(8'h29, 8'h20);
        bus(1'b0, ACS_IDX_AIN_A, 32'h0);
        check("corrected a", rd, 32'h7e1);
        bus(1'b0, ACS_IDX_AIN_B, 32'h0);
        check("corrected b", rd, 32'h7e1);
        run(8'h09, 8'h13);
        check("reversed count", run_slot.size(), 32'h1);
        check("reversed slot", {28'h0, run_slot[0]}, 32'h3);
        for (int r = 0; r < 4; r++)
        begin
            run(8'h01 | 8'(r << 2), 8'h11);
            check("rate len", run_len[0],
                  2 * ((ACS_ADC_CLK_HZ / hz[r] < 20) ? 20
                       : ACS_ADC_CLK_HZ / hz[r]));
        end
        run(8'h08, 8'h87);
        check("loop 0", {28'h0, run_slot[0]}, 32'h7);
        check("loop 1", {28'h0, run_slot[1]}, 32'h8);
        check("loop 2", {28'h0, run_slot[2]}, 32'h7);
        check("double range", {31'h0, run_rng[1]}, 32'h1);
        check("ref range", {31'h0, run_rng[0]}, 32'h0);
        check("last len", run_len[run_len.size()-1], 32'd60);
        print_verdict();
    end
endmodule
